// *** hw/e1_tester_regs.svh ***
// Purpose: Offsets, field positions, reset values and counts of the tester
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
`ifndef E1_TESTER_REGS_SVH
`define E1_TESTER_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_CMD         8'h04
`define REG_STATUS      8'h08
`define REG_ES          8'h0C
`define REG_BES         8'h10
`define REG_SES         8'h14
`define REG_MAP_A_TEST  8'h18
`define REG_MAP_B_TEST  8'h1C
`define REG_MAPPED      8'h20

// ----------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------
`define CTRL_LOOP_LSB   0
`define CTRL_PAT_LSB    2
`define CTRL_REMOTE_BIT 5
`define CTRL_MAPSEL_BIT 6
`define CTRL_USED_MSB   6
`define LOOP_FLD_LINE   2'h1
`define LOOP_FLD_PAYLD  2'h2
`define PAT_FLD_ONES    3'h1
`define PAT_FLD_ZEROS   3'h2
`define PAT_FLD_QALL    3'h3
`define PAT_FLD_QTEST   3'h4
`define CMD_CLEAR_BIT   0
`define CMD_INJECT_BIT  1
`define STAT_SYNC_BIT   0
`define STAT_LOST_BIT   1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CTRL_RESET      32'h0000_0000
`define MAP_RESET       32'h0000_0000
`define QRSS_SEED       20'hF_FFFF

// ----------------------------------------------------------------------
// Framing, sequence and timing figures
// ----------------------------------------------------------------------
`define FAS_BYTE        8'h9B
`define NFAS_BYTE       8'hDF
`define QRSS_LEN        20
`define QRSS_TAP        17
`define QRSS_ZERO_LIMIT 14
`define LOOPUP_LEN      7
`define LOOPUP_TAP      6
`define SYNC_GOOD_BITS  32
`define SYNC_WIN_BITS   64
`define SYNC_LOSS_ERRS  8
`define SEVERE_ERRS     320
`define ACCOUNT_SEC     1
`define E1_LINE_HZ      2048000
`define BITS_PER_SEC    (`ACCOUNT_SEC * `E1_LINE_HZ)

`endif

// *** hw/e1_tester_pkg.sv ***
// Purpose: Types shared by the loopback and pattern tester
// Assumes: Nothing
// Notes:   Register codes live in the regs header
package e1_tester_pkg;

   typedef enum logic [1:0] {
      LOOP_NONE,
      LOOP_LINE,
      LOOP_PAYLOAD
   } loop_mode_e;

   typedef enum logic [2:0] {
      PAT_NONE,
      PAT_ONES,
      PAT_ZEROS,
      PAT_QRSS_ALL,
      PAT_QRSS_TEST
   } pattern_e;

   typedef enum logic {
      SYNC_HUNT,
      SYNC_LOCKED
   } sync_state_e;

endpackage : e1_tester_pkg

// *** hw/qrss_gen.sv ***
// Purpose: 2^20-1 sequence with ones forced after a long zero run
// Assumes: step_i is one line bit; load_i shifts in a received bit
// Notes:   Used as transmit source and as receive reference
`timescale 1ns/1ps
`include "e1_tester_regs.svh"
module qrss_gen #(
   parameter int LEN = `QRSS_LEN,
   parameter int TAP = `QRSS_TAP
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Control
   input  wire logic clear_i,
   input  wire logic step_i,
   input  wire logic load_i,
   input  wire logic load_bit_i,
   // Sequence out
   output logic      raw_o,
   output logic      bit_o
);
   logic [LEN-1:0] state_q;
   logic [3:0]     zrun_q;
   logic           state_zero;
   logic           shift_in;
   logic           run_bit;

   // A stuck all-zero state would never leave; a one is pushed instead
   assign state_zero = (state_q == '0);
   assign raw_o      = state_zero | (state_q[LEN-1] ^ state_q[TAP-1]);
   assign bit_o      = (zrun_q == 4'(`QRSS_ZERO_LIMIT)) ? 1'b1 : raw_o;
   assign shift_in   = load_i ? load_bit_i : raw_o;
   assign run_bit    = load_i ? load_bit_i : bit_o;

   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         state_q <= LEN'(`QRSS_SEED);
         zrun_q  <= 4'h0;
      end else if (step_i) begin
         state_q <= {state_q[LEN-2:0], shift_in};
         zrun_q  <= run_bit ? 4'h0 : zrun_q + 4'h1;
      end
   end

endmodule : qrss_gen

// *** hw/e1_loop_tester.sv ***
// Purpose: Network-side loopbacks, test pattern source and checker
// Assumes: bit_en_i marks one E1 line bit; ts_i, bitpos_i and
//          frame_odd_i give its place, shared by both directions
// Notes:   Registers over classic Wishbone, one-cycle acknowledge
//
// Function
// - Line loop returns whole received stream
// - Line loop keeps line code errors unchanged
// - Payload loop regenerates framing, loops payload
// - Loop setting is line, payload or none
// - Remote loop sends loop-up code, mapped slots
// - All-ones pattern sends ones in timeslots 1 to 31
// - All-zeros pattern sends zeros in timeslots 1 to 31
// - QRSS-all puts sequence in timeslots 1 to 31
// - QRSS-test uses test slots of active map
// - Pattern none restores normal data
// - QRSS uses all eight bits per slot
// - Inject command corrupts the next sent pattern bit
// - Errored second counted for any error seen while in sync
// - Bursty second: over one, under 320 errors
// - Severe second: over 320 errors
// - Report sync and sticky loss of sync
// - Counters cleared by pattern none or clear
// - Non-test slots keep normal traffic
`timescale 1ns/1ps
`include "e1_tester_regs.svh"
module e1_loop_tester
   import e1_tester_pkg::*;
#(
   parameter int BITS_PER_SEC = `BITS_PER_SEC,
   parameter int CNT_W        = 16
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Frame timing
   input  wire logic        bit_en_i,
   input  wire logic [4:0]  ts_i,
   input  wire logic [2:0]  bitpos_i,
   input  wire logic        frame_odd_i,
   // Receive side
   input  wire logic        rx_bit_i,
   input  wire logic        rx_pos_i,
   input  wire logic        rx_neg_i,
   // Normal transmit source
   input  wire logic        user_bit_i,
   input  wire logic        enc_pos_i,
   input  wire logic        enc_neg_i,
   // Toward the network
   output logic             tx_bit_o,
   output logic             tx_pos_o,
   output logic             tx_neg_o,
   // Checker state
   output logic             pattern_sync_o,
   output logic             sync_lost_o
);
   localparam int SEC_W = $clog2(BITS_PER_SEC);

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   function automatic loop_mode_e loop_of(input logic [1:0] f);
      loop_mode_e m;
      m = LOOP_NONE;
      if (f == `LOOP_FLD_LINE)  m = LOOP_LINE;
      if (f == `LOOP_FLD_PAYLD) m = LOOP_PAYLOAD;
      return m;
   endfunction : loop_of

   function automatic pattern_e pat_of(input logic [2:0] f);
      pattern_e p;
      p = PAT_NONE;
      if (f == `PAT_FLD_ONES)  p = PAT_ONES;
      if (f == `PAT_FLD_ZEROS) p = PAT_ZEROS;
      if (f == `PAT_FLD_QALL)  p = PAT_QRSS_ALL;
      if (f == `PAT_FLD_QTEST) p = PAT_QRSS_TEST;
      return p;
   endfunction : pat_of

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return r;
   endfunction : merge

   // ----------------------------------------------------------------
   // Wishbone register file
   // ----------------------------------------------------------------
   logic [31:0]      ctrl_q;
   logic [31:0]      map_a_q;
   logic [31:0]      map_b_q;
   logic [31:0]      mapped_q;
   logic             ack_q;
   logic [31:0]      rdat_q;
   logic [31:0]      rd_mux;
   logic             bus_req;
   logic             bus_wr;
   logic             cmd_wr;
   logic             clear_cmd;
   logic             inject_cmd;
   logic [CNT_W-1:0] es_q;
   logic [CNT_W-1:0] bes_q;
   logic [CNT_W-1:0] ses_q;
   sync_state_e      sync_q;
   logic             lost_q;

   assign bus_req    = wb_cyc_i & wb_stb_i & ~ack_q;
   assign bus_wr     = bus_req & wb_we_i;
   assign cmd_wr     = bus_wr & (wb_adr_i == `REG_CMD) & wb_sel_i[0];
   assign clear_cmd  = cmd_wr & wb_dat_i[`CMD_CLEAR_BIT];
   assign inject_cmd = cmd_wr & wb_dat_i[`CMD_INJECT_BIT];

   always_comb begin
      case (wb_adr_i)
         `REG_CTRL:       rd_mux = ctrl_q;
         `REG_STATUS:     rd_mux = {30'h0000_0000, lost_q,
                                    sync_q == SYNC_LOCKED};
         `REG_ES:         rd_mux = 32'(es_q);
         `REG_BES:        rd_mux = 32'(bes_q);
         `REG_SES:        rd_mux = 32'(ses_q);
         `REG_MAP_A_TEST: rd_mux = map_a_q;
         `REG_MAP_B_TEST: rd_mux = map_b_q;
         `REG_MAPPED:     rd_mux = mapped_q;
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q   <= `CTRL_RESET;
         map_a_q  <= `MAP_RESET;
         map_b_q  <= `MAP_RESET;
         mapped_q <= `MAP_RESET;
      end else if (bus_wr) begin
         case (wb_adr_i)
            `REG_CTRL: ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i)
                                 & 32'h0000_007F;
            `REG_MAP_A_TEST: map_a_q  <= merge(map_a_q, wb_dat_i, wb_sel_i);
            `REG_MAP_B_TEST: map_b_q  <= merge(map_b_q, wb_dat_i, wb_sel_i);
            `REG_MAPPED:     mapped_q <= merge(mapped_q, wb_dat_i, wb_sel_i);
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q  <= bus_req;
         rdat_q <= bus_req ? rd_mux : 32'h0000_0000;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ----------------------------------------------------------------
   // Mode decode and slot selection
   // ----------------------------------------------------------------
   loop_mode_e loop_mode;
   pattern_e   pat_mode;
   logic       remote_on;
   logic       pat_qrss;
   logic       payload_ts;
   logic       test_mark;
   logic       pat_slot;
   logic       loopup_slot;
   logic       clr_all;

   assign loop_mode  = loop_of(ctrl_q[`CTRL_LOOP_LSB +: 2]);
   assign pat_mode   = pat_of(ctrl_q[`CTRL_PAT_LSB +: 3]);
   assign remote_on  = ctrl_q[`CTRL_REMOTE_BIT];
   assign pat_qrss   = (pat_mode == PAT_QRSS_ALL) |
                       (pat_mode == PAT_QRSS_TEST);
   // Timeslot 0 carries framing, so patterns fill slots 1 to 31
   assign payload_ts = (ts_i != 5'h00);
   assign test_mark  = ctrl_q[`CTRL_MAPSEL_BIT] ? map_b_q[ts_i]
                                                 : map_a_q[ts_i];
   assign pat_slot   = payload_ts & (pat_mode != PAT_NONE) &
                       ((pat_mode != PAT_QRSS_TEST) | test_mark);
   assign loopup_slot = remote_on & payload_ts & mapped_q[ts_i];
   assign clr_all    = clear_cmd | (pat_mode == PAT_NONE);

   // ----------------------------------------------------------------
   // Transmit sources
   // ----------------------------------------------------------------
   logic [`LOOPUP_LEN-1:0] lu_q;
   logic                   lu_bit;
   logic                   gen_raw;
   logic                   gen_bit;
   logic                   gen_step;
   logic                   pat_bit;
   logic                   frame_bit;
   logic                   inj_pend_q;
   logic                   pat_sent;
   logic                   tx_bit_d;
   logic                   tx_bit_q;
   logic                   tx_pos_q;
   logic                   tx_neg_q;

   // A literal cannot be indexed, so the framing words get names first
   localparam logic [7:0] FAS_WORD  = `FAS_BYTE;
   localparam logic [7:0] NFAS_WORD = `NFAS_BYTE;

   assign lu_bit    = lu_q[`LOOPUP_LEN-1] ^ lu_q[`LOOPUP_TAP-1];
   assign frame_bit = frame_odd_i ? NFAS_WORD[3'd7 - bitpos_i]
                                  : FAS_WORD[3'd7 - bitpos_i];
   // Every bit of an occupied slot advances the sequence, so it runs at 64K per occupied slot
   assign gen_step  = bit_en_i & pat_slot & pat_qrss & ~loopup_slot;
   assign pat_sent  = bit_en_i & pat_slot & ~loopup_slot &
                      ~(loop_mode == LOOP_PAYLOAD & ~payload_ts);
   assign pat_bit   = (pat_mode == PAT_ONES)  ? 1'b1 :
                      (pat_mode == PAT_ZEROS) ? 1'b0 : gen_bit;

   qrss_gen u_gen (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .clear_i    (pat_mode == PAT_NONE),
      .step_i     (gen_step),
      .load_i     (1'b0),
      .load_bit_i (1'b0),
      .raw_o      (gen_raw),
      .bit_o      (gen_bit)
   );

   always_comb begin
      if (loop_mode == LOOP_PAYLOAD && !payload_ts) begin
         tx_bit_d = frame_bit;
      end else if (loopup_slot) begin
         tx_bit_d = lu_bit;
      end else if (pat_slot) begin
         tx_bit_d = pat_bit ^ inj_pend_q;
      end else if (loop_mode == LOOP_PAYLOAD) begin
         tx_bit_d = rx_bit_i;
      end else begin
         tx_bit_d = user_bit_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lu_q       <= '1;
         inj_pend_q <= 1'b0;
         tx_bit_q   <= 1'b1;
      end else begin
         if (bit_en_i && loopup_slot) lu_q <= {lu_q[`LOOPUP_LEN-2:0], lu_bit};
         // A new request wins over the bit that consumes an older one
         inj_pend_q <= inject_cmd | (inj_pend_q & ~pat_sent);
         if (bit_en_i) tx_bit_q <= tx_bit_d;
      end
   end

   // Line loop bypasses coding entirely so violations pass untouched
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_pos_q <= 1'b0;
         tx_neg_q <= 1'b0;
      end else begin
         tx_pos_q <= (loop_mode == LOOP_LINE) ? rx_pos_i : enc_pos_i;
         tx_neg_q <= (loop_mode == LOOP_LINE) ? rx_neg_i : enc_neg_i;
      end
   end

   assign tx_bit_o = tx_bit_q;
   assign tx_pos_o = tx_pos_q;
   assign tx_neg_o = tx_neg_q;

   // ----------------------------------------------------------------
   // Pattern checker
   // ----------------------------------------------------------------
   logic       chk_en;
   logic       chk_raw;
   logic       chk_bit;
   logic       chk_exp;
   logic       miss;
   logic [5:0] good_q;
   logic [5:0] win_q;
   logic [3:0] bad_q;
   logic       hunting;

   assign hunting = (sync_q == SYNC_HUNT);
   assign chk_en  = bit_en_i & pat_slot & ~loopup_slot & payload_ts;
   assign chk_exp = !pat_qrss ? (pat_mode == PAT_ONES)
                              : (hunting ? chk_raw : chk_bit);
   assign miss    = chk_en & (rx_bit_i ^ chk_exp);

   // While hunting the reference is seeded from the line itself
   qrss_gen u_chk (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .clear_i    (clr_all),
      .step_i     (chk_en & pat_qrss),
      .load_i     (hunting),
      .load_bit_i (rx_bit_i),
      .raw_o      (chk_raw),
      .bit_o      (chk_bit)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i || pat_mode == PAT_NONE) begin
         sync_q <= SYNC_HUNT;
         good_q <= 6'h00;
         win_q  <= 6'h00;
         bad_q  <= 4'h0;
      end else if (chk_en) begin
         case (sync_q)
            SYNC_HUNT: begin
               good_q <= miss ? 6'h00 : good_q + 6'h01;
               if (!miss && good_q == 6'(`SYNC_GOOD_BITS - 1)) begin
                  sync_q <= SYNC_LOCKED;
                  win_q  <= 6'h00;
                  bad_q  <= 4'h0;
               end
            end
            SYNC_LOCKED: begin
               win_q <= win_q + 6'h01;
               bad_q <= (win_q == 6'(`SYNC_WIN_BITS - 1)) ? 4'h0
                                                          : bad_q + 4'(miss);
               if (miss && bad_q == 4'(`SYNC_LOSS_ERRS - 1)) begin
                  sync_q <= SYNC_HUNT;
                  good_q <= 6'h00;
               end
            end
            default: sync_q <= SYNC_HUNT;
         endcase
      end
   end

   logic sync_drop;
   assign sync_drop = chk_en & ~hunting & miss &
                      (bad_q == 4'(`SYNC_LOSS_ERRS - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i) lost_q <= 1'b0;
      else       lost_q <= sync_drop | (lost_q & ~clr_all);
   end

   assign pattern_sync_o = ~hunting;
   assign sync_lost_o    = lost_q;

   // ----------------------------------------------------------------
   // One-second accounting
   // ----------------------------------------------------------------
   logic [SEC_W-1:0] sec_q;
   logic             sec_tick;
   logic [9:0]       err_q;
   logic [9:0]       err_sum;
   logic             cnt_miss;

   assign sec_tick = bit_en_i & (sec_q == SEC_W'(BITS_PER_SEC - 1));
   assign cnt_miss = miss & ~hunting;
   assign err_sum  = (err_q == 10'h3FF) ? err_q : err_q + 10'(cnt_miss);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sec_q <= '0;
      end else if (bit_en_i) begin
         sec_q <= sec_tick ? '0 : sec_q + SEC_W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || clr_all) begin
         err_q <= 10'h000;
         es_q  <= '0;
         bes_q <= '0;
         ses_q <= '0;
      end else if (sec_tick) begin
         err_q <= 10'(cnt_miss);
         if (err_q != 10'h000 && ~&es_q) es_q <= es_q + CNT_W'(1);
         if (err_q > 10'h001 && err_q < 10'(`SEVERE_ERRS) && ~&bes_q)
            bes_q <= bes_q + CNT_W'(1);
         if (err_q > 10'(`SEVERE_ERRS) && ~&ses_q)
            ses_q <= ses_q + CNT_W'(1);
      end else begin
         err_q <= err_sum;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_second_close;
      sec_tick && !clr_all;
   endsequence

   sequence s_plain_bit;
      bit_en_i && loop_mode == LOOP_NONE && !remote_on;
   endsequence

   a_line_rails: assert property (loop_mode == LOOP_LINE |=>
      tx_pos_o == $past(rx_pos_i) && tx_neg_o == $past(rx_neg_i))
      else $error("line loop did not return received rails");
   a_payload_data: assert property (bit_en_i && payload_ts &&
      loop_mode == LOOP_PAYLOAD && !remote_on && !pat_slot
      |=> tx_bit_o == $past(rx_bit_i))
      else $error("payload loop did not return payload bit");
   a_ones_fill: assert property (s_plain_bit ##0 pat_mode == PAT_ONES
      && payload_ts && !inj_pend_q |=> tx_bit_o)
      else $error("all-ones pattern sent a zero");
   a_zeros_fill: assert property (s_plain_bit ##0 pat_mode == PAT_ZEROS
      && payload_ts && !inj_pend_q |=> !tx_bit_o)
      else $error("all-zeros pattern sent a one");
   a_traffic_kept: assert property (s_plain_bit ##0
      pat_mode == PAT_QRSS_TEST && !test_mark
      |=> tx_bit_o == $past(user_bit_i))
      else $error("non-test slot lost normal traffic");
   a_none_normal: assert property (s_plain_bit ##0
      pat_mode == PAT_NONE |=> tx_bit_o == $past(user_bit_i))
      else $error("pattern none did not restore data");
   a_es_step: assert property (s_second_close ##0 err_q != 10'h000
      && !(&es_q) |=> es_q == $past(es_q) + 1'b1)
      else $error("errored second not counted");
   a_ses_step: assert property (s_second_close ##0
      err_q > 10'(`SEVERE_ERRS) && !(&ses_q) |=> ses_q == $past(ses_q) + 1'b1)
      else $error("severe second not counted");
   a_clear_zero: assert property (clr_all |=>
      es_q == '0 && bes_q == '0 && ses_q == '0)
      else $error("counters not cleared");
   a_sticky_set: assert property (sync_drop |=> lost_q && !pattern_sync_o)
      else $error("sync loss not recorded");
   a_inject_hit: assert property (inject_cmd |=> inj_pend_q)
      else $error("inject request dropped");

endmodule : e1_loop_tester

// *** verification/far_end_line.sv ***
// Purpose: Far-end line and terminal model with loop-timed frame timing
// Assumes: One line bit every four clocks, 32 slots of 8 bits a frame
// Notes:   The loop returns sent bits one frame later, slot aligned
`timescale 1ns/1ps
module far_end_line (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Toward far end
   input  wire logic       tx_bit_i,
   input  wire logic       loop_i,
   // Frame timing and line
   output logic            bit_en_o,
   output logic [4:0]      ts_o,
   output logic [2:0]      bitpos_o,
   output logic            frame_odd_o,
   output logic            rx_bit_o,
   output logic            rx_pos_o,
   output logic            rx_neg_o,
   output logic            user_bit_o,
   output logic            enc_pos_o,
   output logic            enc_neg_o
);
   logic [1:0]   div_q;
   logic [7:0]   bit_q;
   logic [255:0] dly_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q       <= 2'h0;
         bit_q       <= 8'h00;
         frame_odd_o <= 1'b0;
      end else begin
         div_q <= div_q + 2'h1;
         if (bit_en_o) begin
            bit_q <= bit_q + 8'h01;
            dly_q <= {dly_q[254:0], tx_bit_i};
            if (bit_q == 8'hFF) frame_odd_o <= ~frame_odd_o;
         end
      end
   end
   assign bit_en_o   = (div_q == 2'h3);
   assign ts_o       = bit_q[7:3];
   assign bitpos_o   = bit_q[2:0];
   // Far end answers with a line loop back toward the sender
   assign rx_bit_o   = loop_i ? dly_q[254] : bit_q[0];
   // Both rails high at times: a violation the loop must keep
   assign rx_pos_o   = div_q[0];
   assign rx_neg_o   = div_q[1];
   assign enc_pos_o  = ~div_q[0];
   assign enc_neg_o  = ~div_q[1];
   assign user_bit_o = bit_q[1] ^ bit_q[4];
endmodule : far_end_line

// *** verification/e1_loop_tester_bench.sv ***
// Purpose: Register, loop and pattern tests of the tester
// Assumes: One-second interval shortened to two frames
// Notes:   Far end loops the stream back for checker runs
`timescale 1ns/1ps
module e1_loop_tester_bench;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, lp = 0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000, rd, dat_o;
   logic ack, ben, fodd, rxb, rxp, rxn, ub, ep, en, txb, txp, txn, syn, lost;
   logic [4:0] ts;
   logic [2:0] bp;
   int fails = 0, num_checks = 0, cyc_n = 0;
   e1_loop_tester #(.BITS_PER_SEC(512)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .bit_en_i(ben), .ts_i(ts), .bitpos_i(bp), .frame_odd_i(fodd),
      .rx_bit_i(rxb), .rx_pos_i(rxp), .rx_neg_i(rxn), .user_bit_i(ub),
      .enc_pos_i(ep), .enc_neg_i(en), .tx_bit_o(txb), .tx_pos_o(txp),
      .tx_neg_o(txn), .pattern_sync_o(syn), .sync_lost_o(lost));
   far_end_line u_far (.clk_i(clk_i), .rst_i(rst_i), .tx_bit_i(txb),
      .loop_i(lp), .bit_en_o(ben), .ts_o(ts), .bitpos_o(bp),
      .frame_odd_o(fodd), .rx_bit_o(rxb), .rx_pos_o(rxp), .rx_neg_o(rxn),
      .user_bit_o(ub), .enc_pos_o(ep), .enc_neg_o(en));
   initial forever #2.5 clk_i = ~clk_i;
   // Ceiling well above the longest run of about 28000 cycles
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 80000) begin
         fails++;
         tally_and_finish();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Starts on a fresh edge so the request always rises right after one
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask : wb
   // First tx bit of the next slot 3; src 0 constant, 1 user, 2 rx bit
   task automatic chk_tx(input string n, input logic e,
                         input logic [1:0] src);
      logic u;
      do @(posedge clk_i); while (!(ben && ts == 5'd3 && bp == 3'd0));
      u = src[1] ? rxb : ub;
      #1 chk(n, {31'h0, (src != 2'd0) ? u : e}, {31'h0, txb});
   endtask : chk_tx
   task automatic tally_and_finish();
      if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   initial begin
      logic p, q;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(0, 8'h00, 0); chk("ctrl_rst", 32'h0000_0000, rd);
      wb(0, 8'h08, 0); chk("stat_rst", 32'h0000_0000, rd);
      wb(1, 8'h40, 32'hFFFF_FFFF); wb(0, 8'h40, 0);
      chk("unmapped", 32'h0000_0000, rd);
      wb(1, 8'h00, 32'hFFFF_FF86); wb(0, 8'h00, 0);
      chk("ctrl_rw", 32'h0000_0006, rd);
      wb(1, 8'h00, 32'h0000_0004); chk_tx("ones", 1, 0);
      wb(1, 8'h00, 32'h0000_0008); chk_tx("zeros", 0, 0);
      wb(1, 8'h00, 32'h0000_0000); chk_tx("none", 0, 1);
      wb(1, 8'h00, 32'h0000_0010); chk_tx("qtest", 0, 1);
      wb(1, 8'h20, 32'h0000_0008);
      // Enable early in the frame so slot 3 starts the loop-up code
      do @(posedge clk_i); while (ts != 5'd0);
      wb(1, 8'h00, 32'h0000_0020); chk_tx("loopup", 0, 0);
      wb(1, 8'h00, 32'h0000_0002); chk_tx("payload", 0, 2);
      wb(1, 8'h00, 32'h0000_0001);
      repeat (3) begin
         @(posedge clk_i);
         p = rxp;
         q = rxn;
         #1 chk("line_pos", {31'h0, p}, {31'h0, txp});
         chk("line_neg", {31'h0, q}, {31'h0, txn});
      end
      @(posedge clk_i) lp <= 1'b1;
      wb(1, 8'h00, 32'h0000_000C);
      repeat (8192) @(posedge clk_i);
      wb(0, 8'h08, 0); chk("sync_on", 32'h0000_0001, rd);
      wb(1, 8'h04, 32'h0000_0002);
      repeat (6144) @(posedge clk_i);
      wb(0, 8'h0C, 0); chk("es_inj", 32'h0000_0001, rd);
      wb(0, 8'h10, 0); chk("bes_one", 32'h0000_0000, rd);
      wb(0, 8'h14, 0); chk("ses_one", 32'h0000_0000, rd);
      wb(1, 8'h04, 32'h0000_0001); wb(0, 8'h0C, 0);
      chk("es_clr", 32'h0000_0000, rd);
      lp <= 1'b0;
      repeat (8192) @(posedge clk_i);
      wb(0, 8'h08, 0); chk("lost", 32'h0000_0002, rd);
      tally_and_finish();
   end
endmodule : e1_loop_tester_bench
